// ### rtl/bbsram_pkg.sv
// Purpose: Shared constants for the battery-backed SRAM host controller
// Assumes: 100 MHz sys_clk, 10 ns period
// Notes:   Times are kept in ns, cycle counts derived from them
package bbsram_pkg;
    // ==========================================================
    // Geometry
    localparam int ADDR_W = 11;               // Byte address width
    localparam int DATA_W = 8;                // Data bus width
    localparam int CLK_PERIOD_NS = 10;        // sys_clk period
    localparam int SPEED_GRADE = 2;           // 0 fast, 1 mid, 2 slow

    // ==========================================================
    // Timing in ns, indexed by speed grade
    localparam int T_ADDR_ACCESS_NS[3] = '{70, 150, 200};    // address_access_delay
    localparam int T_OE_ACCESS_NS[3] = '{35, 75, 80};        // output_drive_access_delay
    localparam int T_FLOAT_NS[3] = '{25, 35, 40};            // Select/enable high to float
    localparam int T_WRITE_FLOAT_NS[3] = '{25, 50, 60};      // write_to_float_delay
    localparam int T_ADDR_HOLD_NS[3] = '{0, 10, 10};         // strobe_release_address_hold
    localparam int T_DATA_SETUP_NS[3] = '{30, 40, 60};       // write_data_setup
    localparam int T_DATA_HOLD_NS = 5;                       // write_data_hold
    localparam int T_STROBE_NS[3] = '{50, 90, 120};          // Write strobe pulse width
    localparam int T_ADDR_SETUP_NS[3] = '{60, 120, 140};     // Address valid to strobe high

    // All times round up, least and longest alike; never below one cycle
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // ==========================================================
    // Cycle counts for the chosen grade (read waits are least times for the host)
    // Read waits add one cycle of margin plus the two synchroniser flops on the bus,
    // so the first flop samples the bus only after the access time has passed
    localparam int RD_WAIT_CYC = cyc_up(T_ADDR_ACCESS_NS[SPEED_GRADE]) + 3;
    localparam int OE_WAIT_CYC = cyc_up(T_OE_ACCESS_NS[SPEED_GRADE]) + 3;
    localparam int FLOAT_CYC = cyc_up(T_FLOAT_NS[SPEED_GRADE]);
    localparam int WFLOAT_CYC = cyc_up(T_WRITE_FLOAT_NS[SPEED_GRADE]);
    localparam int STROBE_CYC = cyc_up(T_STROBE_NS[SPEED_GRADE] > T_ADDR_SETUP_NS[SPEED_GRADE]
        ? T_STROBE_NS[SPEED_GRADE] : T_ADDR_SETUP_NS[SPEED_GRADE]);
    localparam int HOLD_CYC = cyc_up(T_ADDR_HOLD_NS[SPEED_GRADE] > T_DATA_HOLD_NS
        ? T_ADDR_HOLD_NS[SPEED_GRADE] : T_DATA_HOLD_NS);
    localparam int CNT_W = 6;                 // Width of the phase counter

    // ==========================================================
    // Controller states
    typedef enum logic [2:0] {
        IDLE, RD_WAIT, RD_FLOAT, WR_SETUP, WR_STROBE, WR_HOLD, FAULT
    } bbs_state_type;
endpackage

// ### rtl/bbs_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Asynchronous input, single sys_clk domain
// Notes:   First flop feeds only the second
`timescale 1ns/10ps
module bbs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    // ==========================================================
    // Synchroniser stages
    logic [WIDTH-1:0] meta_q; // First stage, read only by second stage
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    // Next values are just the shift
    always_comb begin
        meta_d = asyncIn;
        sync_d = meta_q;
    end

    // Register both stages
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= meta_d;
            syncOut <= sync_d;
        end
    end
endmodule // bbs_sync

// ### rtl/bbs_host.sv
// Purpose: Host-side controller driving a 2K x 8 battery-backed async SRAM
// Assumes: 100 MHz sys_clk; timing for the grade chosen in the package
// Notes:   One access at a time; user waits on reqReady
//
// How it works
// - Host keeps address stable during write
// - Host holds address after strobe rises
// - Host sets up and holds write data
// - Host keeps strobe low long enough
// - Select-ended write keeps select low enough
// - Address valid long before strobe rises
// - Host keeps output enable high writing
`timescale 1ns/10ps
module bbs_host (
    input wire logic sys_clk,
    input wire logic rstn,
    // User side
    input wire logic reqValid,          // Access request
    input wire logic reqWrite,          // 1 write, 0 read
    input wire logic [10:0] reqAddr,    // Byte address
    input wire logic [7:0] reqWdata,    // Write data
    output logic reqReady,              // Request taken this cycle
    output logic rspValid,              // One-cycle completion pulse
    output logic [7:0] rspRdata,        // Read data
    output logic rspError,              // Access aborted by power fail
    input wire logic powerGood,         // Supply monitor, async
    // Memory pins
    output logic [10:0] byteAddress,    // byte_address pins
    output logic chipSelectN,           // Chip enable, active low
    output logic outputEnableN,         // Output enable, active low
    output logic writeStrobeN,          // Write enable, active low
    input wire logic [7:0] dataBusIn,   // data_bus as seen on the wire
    output logic [7:0] dataBusOut,      // data_bus drive value
    output logic dataBusOe              // High while host drives data_bus
);
    // ==========================================================
    // Input synchronisation
    logic [8:0] syncIn; // {powerGood, data bus}
    logic pgSync;
    logic [7:0] busSync;

    // Pins from outside pass two flops before use
    bbs_sync #(.WIDTH(9)) u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .asyncIn({powerGood, dataBusIn}),
        .syncOut(syncIn)
    );
    assign pgSync = syncIn[8];
    assign busSync = syncIn[7:0];

    // ==========================================================
    // State
    bbsram_pkg::bbs_state_type state_q, state_d;
    logic [bbsram_pkg::CNT_W-1:0] cnt_q, cnt_d;   // Phase timer
    logic [10:0] addr_q, addr_d;                   // Latched address
    logic [7:0] wdata_q, wdata_d;                  // Latched write data
    logic [7:0] rdata_q, rdata_d;                  // Captured read data
    logic csN_q, csN_d;
    logic oeN_q, oeN_d;
    logic weN_q, weN_d;
    logic drive_q, drive_d;                        // Host drives bus
    logic done_q, done_d;                          // Completion pulse
    logic err_q, err_d;                            // Completion error flag

    // Load a phase count, cut to counter width
    function automatic logic [bbsram_pkg::CNT_W-1:0] ld(input int c);
        return bbsram_pkg::CNT_W'(c - 1);
    endfunction

    // ==========================================================
    // Next-state logic
    always_comb begin
        state_d = state_q;
        cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        csN_d = csN_q;
        oeN_d = oeN_q;
        weN_d = weN_q;
        drive_d = drive_q;
        done_d = 1'b0;
        err_d = 1'b0;
        unique case (state_q)
            bbsram_pkg::IDLE: begin
                // Pins idle: deselected, bus released
                if (reqValid && pgSync) begin
                    addr_d = reqAddr;
                    wdata_d = reqWdata;
                    csN_d = 1'b0;
                    if (reqWrite) begin
                        // Output enable stays high; address settles first
                        oeN_d = 1'b1;
                        drive_d = 1'b1;
                        cnt_d = ld(1);
                        state_d = bbsram_pkg::WR_SETUP;
                    end else begin
                        // Read: strobe high, select and enable low together
                        oeN_d = 1'b0;
                        cnt_d = ld(bbsram_pkg::RD_WAIT_CYC > bbsram_pkg::OE_WAIT_CYC
                            ? bbsram_pkg::RD_WAIT_CYC : bbsram_pkg::OE_WAIT_CYC);
                        state_d = bbsram_pkg::RD_WAIT;
                    end
                end
            end
            bbsram_pkg::RD_WAIT: begin
                // Sample only after the later of all access times plus sync delay
                if (cnt_q == '0) begin
                    rdata_d = busSync;
                    csN_d = 1'b1;
                    oeN_d = 1'b1;
                    cnt_d = ld(bbsram_pkg::FLOAT_CYC);
                    state_d = bbsram_pkg::RD_FLOAT;
                end
            end
            bbsram_pkg::RD_FLOAT: begin
                // Let the memory release the bus before anything else
                if (cnt_q == '0) begin
                    done_d = 1'b1;
                    state_d = bbsram_pkg::IDLE;
                end
            end
            bbsram_pkg::WR_SETUP: begin
                // Address and data stable before the strobe falls
                if (cnt_q == '0) begin
                    weN_d = 1'b0;
                    cnt_d = ld(bbsram_pkg::STROBE_CYC);
                    state_d = bbsram_pkg::WR_STROBE;
                end
            end
            bbsram_pkg::WR_STROBE: begin
                // Strobe width covers pulse width, address and data setup
                if (cnt_q == '0) begin
                    weN_d = 1'b1;
                    csN_d = 1'b1;
                    cnt_d = ld(bbsram_pkg::HOLD_CYC);
                    state_d = bbsram_pkg::WR_HOLD;
                end
            end
            bbsram_pkg::WR_HOLD: begin
                // Address and data held after the strobe rises
                if (cnt_q == '0) begin
                    drive_d = 1'b0;
                    done_d = 1'b1;
                    state_d = bbsram_pkg::IDLE;
                end
            end
            bbsram_pkg::FAULT: begin
                // Supply gone: stay deselected until it returns
                if (pgSync) begin
                    state_d = bbsram_pkg::IDLE;
                end
            end
        endcase
        // Power fail aborts any access, raises select, enable and strobe, and releases the bus
        if (!pgSync && state_q != bbsram_pkg::FAULT) begin
            csN_d = 1'b1;
            oeN_d = 1'b1;
            weN_d = 1'b1;
            drive_d = 1'b0;
            if (state_q != bbsram_pkg::IDLE) begin
                done_d = 1'b1;
                err_d = 1'b1;
            end
            state_d = bbsram_pkg::FAULT;
        end
    end

    // ==========================================================
    // State registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= bbsram_pkg::IDLE;
            cnt_q <= '0;
            addr_q <= 11'h000;
            wdata_q <= 8'h00;
            rdata_q <= 8'h00;
            csN_q <= 1'b1;
            oeN_q <= 1'b1;
            weN_q <= 1'b1;
            drive_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            csN_q <= csN_d;
            oeN_q <= oeN_d;
            weN_q <= weN_d;
            drive_q <= drive_d;
            done_q <= done_d;
            err_q <= err_d;
        end
    end

    // ==========================================================
    // Outputs; a write blocked by the low-battery flag looks normal here,
    // software checks it by readback
    assign reqReady = (state_q == bbsram_pkg::IDLE) && pgSync;
    assign rspValid = done_q;
    assign rspRdata = rdata_q;
    assign rspError = err_q;
    assign byteAddress = addr_q;
    assign chipSelectN = csN_q;
    assign outputEnableN = oeN_q;
    assign writeStrobeN = weN_q;
    assign dataBusOut = wdata_q;
    assign dataBusOe = drive_q;
endmodule // bbs_host

// ### bench/bbs_sram_model.sv
// Purpose: Behavioural 2K x 8 battery-backed SRAM facing bbs_host
// Assumes: Pins come straight from the host
// Notes:   Resolves the bus wire; released bus toggles every ns
`timescale 1ns/10ps
module bbs_sram_model #(
    parameter int ACC_NS = bbsram_pkg::T_ADDR_ACCESS_NS[bbsram_pkg::SPEED_GRADE] // Worst access
) (
    input wire logic [10:0] byteAddress,
    input wire logic chipSelectN,
    input wire logic outputEnableN,
    input wire logic writeStrobeN,
    input wire logic [7:0] dataBusOut,
    input wire logic dataBusOe,
    input wire logic powerGood,
    input wire logic batteryLow,
    output logic [7:0] busLevel,
    output logic lowBatteryFlag
);
    logic [7:0] mem [2048];
    time tChg = 0; // Last address or drive change
    wire drive = powerGood && !chipSelectN && !outputEnableN && writeStrobeN;
    wire wrActive = powerGood && !chipSelectN && !writeStrobeN;
    // ==========================================
    // Known fill so stale reads are checkable
    initial begin
        for (int i = 0; i < 2048; i++) mem[i] = i[7:0] ^ 8'hA5;
        busLevel = 8'h00;
        lowBatteryFlag = 1'b0;
    end
    // Battery check on each supply rise
    always @(posedge powerGood) lowBatteryFlag = batteryLow;
    // Write lands at the earlier rising edge
    always @(negedge wrActive) begin
        if (!powerGood) mem[byteAddress] = ~dataBusOut;
        else if (lowBatteryFlag) lowBatteryFlag = 1'b0;
        else mem[byteAddress] = dataBusOut;
    end
    // Old data drops at once on an address change, the harshest case allowed
    always @(byteAddress, drive) tChg = $time;
    // Garbage until access time; never holds a stale level
    always #1 begin
        if (dataBusOe) busLevel = dataBusOut;
        else if (drive && $time - tChg >= ACC_NS) busLevel = mem[byteAddress];
        else busLevel = ~busLevel;
    end
endmodule // bbs_sram_model

// ### bench/bbs_host_checker.sv
// Purpose: Pin timing assertions for bbs_host
// Assumes: Default grade, 10 ns clock
// Notes:   Checks other than chk_fail_deselect pause while supply is bad
`timescale 1ns/10ps
module bbs_host_checker (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic rspValid,
    input wire logic powerGood,
    input wire logic [10:0] byteAddress,
    input wire logic chipSelectN,
    input wire logic outputEnableN,
    input wire logic writeStrobeN,
    input wire logic [7:0] dataBusOut,
    input wire logic dataBusOe
);
    logic [4:0] weLow_q, weLow_d; // Strobe low cycles
    logic [4:0] addrAge_q, addrAge_d; // Cycles since address moved
    logic [10:0] addrPrev_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn || !powerGood);
    // ==========================================
    // Counters; address age saturates at 5'h1F, strobe count only clears while strobe is high
    always_comb begin
        weLow_d = writeStrobeN ? 5'h00 : weLow_q + 5'h01;
        addrAge_d = (byteAddress != addrPrev_q) ? 5'h00 : addrAge_q + {4'h0, addrAge_q != 5'h1F};
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            weLow_q <= 5'h00;
            addrAge_q <= 5'h00;
            addrPrev_q <= 11'h000;
        end else begin
            weLow_q <= weLow_d;
            addrAge_q <= addrAge_d;
            addrPrev_q <= byteAddress;
        end
    end
    sequence strobeEnd;
        $rose(writeStrobeN);
    endsequence
    sequence readSpan;
        !outputEnableN [*8] ##1 !outputEnableN [*8] ##1 !outputEnableN [*7];
    endsequence
    chk_addr_steady: assert property (!writeStrobeN |-> $stable(byteAddress))
        else $error("address moved during write");
    chk_addr_hold: assert property (strobeEnd |-> $stable(byteAddress) && dataBusOe)
        else $error("address or data not held");
    chk_strobe_width: assert property (strobeEnd |-> weLow_q >= 5'h0C)
        else $error("write strobe too short");
    chk_addr_setup: assert property (strobeEnd |-> addrAge_q >= 5'h0E)
        else $error("address setup too short");
    chk_data_setup: assert property (strobeEnd |-> $past(dataBusOe, 7) && dataBusOut == $past(dataBusOut, 7))
        else $error("write data setup too short");
    chk_select_width: assert property ($rose(chipSelectN) |-> !$past(chipSelectN, 12))
        else $error("select low too short");
    chk_oe_quiet: assert property (!writeStrobeN || dataBusOe |-> outputEnableN)
        else $error("output enable low while writing");
    chk_fail_deselect: assert property (disable iff (!rstn) !powerGood [*3] |=> chipSelectN && writeStrobeN && !dataBusOe)
        else $error("pins active in power fail");
    chk_read_wait: assert property ($fell(outputEnableN) |-> readSpan ##1 outputEnableN ##4 rspValid)
        else $error("read wait wrong");
    chk_write_done: assert property (strobeEnd |-> ##1 rspValid && !dataBusOe)
        else $error("write completion wrong");
endmodule // bbs_host_checker
bind bbs_host bbs_host_checker chk (.*);

// ### bench/battery_backed_async_sram_port_bench.sv
// Purpose: Self-checking bench for bbs_host with SRAM model
// Assumes: 100 MHz sys_clk, inputs move on falling edges
// Notes:   Rows first, then power fail, battery and reset cases
`timescale 1ns/10ps
module battery_backed_async_sram_port_bench;
    typedef struct {logic wr; logic [10:0] a; logic [7:0] d;} bbs_row_type;
    logic sys_clk = 1'b0, rstn = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
    logic powerGood = 1'b1, batteryLow = 1'b0;
    logic [10:0] reqAddr = 11'h000, byteAddress;
    logic [7:0] reqWdata = 8'h00, rspRdata, dataBusOut, busLevel;
    logic reqReady, rspValid, rspError, chipSelectN, outputEnableN, writeStrobeN;
    logic dataBusOe, lowBatteryFlag;
    int miscompares = 0, checks_done = 0;
    // Edge addresses and back-to-back ops; read rows hold expected data
    bbs_row_type rows [9] = '{'{1, 11'h7FF, 8'h5A}, '{1, 11'h000, 8'hC3}, '{0, 11'h7FF, 8'h5A},
        '{0, 11'h000, 8'hC3}, '{1, 11'h400, 8'hFF}, '{1, 11'h401, 8'h00}, '{0, 11'h401, 8'h00},
        '{0, 11'h400, 8'hFF}, '{0, 11'h123, 8'h86}};
    always #5 sys_clk = ~sys_clk;
    bbs_host uut (.*, .dataBusIn(busLevel));
    bbs_sram_model mem (.*);
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One access, bounded waits on ready and completion
    task automatic access(input logic wr, input logic [10:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge sys_clk);
        reqValid = 1'b1;
        reqWrite = wr;
        reqAddr = a;
        reqWdata = d;
        while (reqReady !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        reqValid = 1'b0;
        while (rspValid !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        check("done", 8'h00, {7'h00, n >= 100});
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #50000;
        miscompares++;
        results();
    end
    initial begin
        repeat (8) @(negedge sys_clk);
        rstn = 1'b1;
        foreach (rows[i]) begin
            access(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) check("rdata", rows[i].d, rspRdata);
            check("error", 8'h00, {7'h00, rspError});
        end
        // Supply fails in the middle of a write strobe
        fork
            access(1'b1, 11'h010, 8'h3C);
            begin
                repeat (8) @(negedge sys_clk);
                powerGood = 1'b0;
            end
        join
        check("fail error", 8'h01, {7'h00, rspError});
        check("fail ready", 8'h00, {7'h00, reqReady});
        batteryLow = 1'b1;
        repeat (4) @(negedge sys_clk);
        powerGood = 1'b1;
        @(negedge sys_clk);
        check("battery flag", 8'h01, {7'h00, lowBatteryFlag});
        access(1'b1, 11'h011, 8'h77);
        check("battery flag", 8'h00, {7'h00, lowBatteryFlag});
        access(1'b0, 11'h011, 8'h00);
        check("kept byte", 8'hB4, rspRdata);
        access(1'b1, 11'h011, 8'h77);
        access(1'b0, 11'h011, 8'h00);
        check("second write", 8'h77, rspRdata);
        // Reset lands in the middle of a read
        @(negedge sys_clk);
        reqValid = 1'b1;
        reqWrite = 1'b0;
        @(negedge sys_clk);
        reqValid = 1'b0;
        repeat (5) @(negedge sys_clk);
        rstn = 1'b0;
        @(negedge sys_clk);
        check("reset pins", 8'h03, {6'h00, chipSelectN, outputEnableN});
        rstn = 1'b1;
        access(1'b0, 11'h7FF, 8'h00);
        check("after reset", 8'h5A, rspRdata);
        results();
    end
endmodule // battery_backed_async_sram_port_bench
